// ---- common/ct_cfg.svh ----
// Purpose: offsets, fields, codes and reset values of the counter/timer pair
// Assumes: 4-bit device register address, 32-bit AHB-Lite word addresses
// Notes:   all numbers shared by both ends live here
`ifndef CT_CFG_SVH
`define CT_CFG_SVH

// device register addresses
`define CT_A_CLK_SEL   4'h1
`define CT_A_CMD_A     4'h2
`define CT_A_AUX_CTRL  4'h4
`define CT_A_IRQ       4'h5
`define CT_A_CNT_HI    4'h6
`define CT_A_CNT_LO    4'h7
`define CT_A_CMD_B     4'ha
`define CT_A_START     4'he
`define CT_A_STOP      4'hf

// command codes, upper nibble of a command write
`define CT_CMD_TO_ON   4'ha
`define CT_CMD_TO_OFF  4'hc

// field positions
`define CT_RDY_BIT     3
`define CT_AUX_TIMER   6
`define CT_AUX_SRC_HI  5
`define CT_AUX_SRC_LO  4

// clock source codes of the aux control field
`define CT_SRC_X1      2'h0
`define CT_SRC_X1_16   2'h1
`define CT_SRC_EXT     2'h2

// prescaler terminal count for the x1/16 source
`define CT_PRE_LAST    4'hf

// reset values
`define CT_RST_BYTE    8'h00
`define CT_RST_CNT     16'h0000

// host register byte offsets
`define HOST_A_CMD     8'h00
`define HOST_A_STATUS  8'h04
`define HOST_A_RX_EV   8'h08

// host command and status word fields
`define HOST_CMD_RD    15
`define HOST_STAT_BUSY 8
`define HOST_STAT_IRQ  9

`endif

// ---- common/ct_pkg.sv ----
// Purpose: shared types of the counter/timer pair
// Assumes: constants come from ct_cfg.svh
// Notes:   state codes are one-hot
package ct_pkg;

  // host sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_STRB = 3'b010,
    H_WAIT = 3'b100
  } host_state_t;

  // operating mode of the counter
  typedef enum logic [2:0] {
    M_COUNTER = 3'b001,
    M_TIMER   = 3'b010,
    M_TIMEOUT = 3'b100
  } ct_mode_t;

endpackage : ct_pkg

// ---- common/ct_if.sv ----
// Purpose: byte register bus and receiver load events between host and counter
// Assumes: both ends run on the same hclk
// Notes:   wr and rd are one-cycle strobes
`timescale 1ns/1ps
interface ct_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rx_load_a;
  logic       rx_load_b;
  logic       irq_n;

  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    input  rx_load_a,
    input  rx_load_b,
    output irq_n
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    output rx_load_a,
    output rx_load_b,
    input  irq_n
  );
endinterface : ct_if

// ---- verilog/ct_device.sv ----
// Purpose: 16-bit counter/timer with receive time-out mode of a dual uart
// Assumes: byte register bus on ct_if, receiver loads as one-cycle pulses
// Notes:   counter clock is a tick from x1, x1/16 or the external pin
// Functional notes
// - timer mode count reads carry no meaning
// - counter-clocked receiver/transmitter runs 16x mode
// - divisor is input clock over 32 times baud
// - counter mode: reach zero, set ready, output low
// - after zero wrap and count silently
// - count reads return live counter value
// - command 0xA enables, 0xC disables time-out
// - start/stop ignored in time-out mode
// - rx load: one clock, reload, restart
// - expiry sets ready, masked interrupt follows
// - late character clears ready and interrupt
// - time-out-on clears ready, holds counter stopped
// - both channels on: restart on either load
// - software enables time-out on one channel; the bench turns it on for both A and B
// - idle irq status reads all zeros
// - software sets time-out above one character
// - start read loads divisor into counter
// - stop read clears counter ready
// - timer: square wave, ready each falling edge
// - aux control selects source and mode
`timescale 1ns/1ps
`include "ct_cfg.svh"
module ct_device (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  ct_if.device            bus,
  input  wire logic       ext_clk_pin,
  output logic            ct_out,
  output logic      [3:0] ct_clk_sel,
  output logic      [3:0] os16_mode
);

  logic [7:0]  clk_sel_r, aux_ctrl_r, irq_mask_r, cnt_hi_r, cnt_lo_r, rdata_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0]  pend_r, pend_nxt;
  logic [3:0]  sel_r, pre_r;
  logic        to_a_r, to_b_r, run_r, run_nxt, out_r, out_nxt, rdy_r, rdy_set;
  logic        irq_n_r, ext_s1_r, ext_s2_r, ext_s3_r;
  ct_pkg::ct_mode_t mode;

  // register decodes
  wire wr_clk_sel = bus.wr && (bus.addr == `CT_A_CLK_SEL);
  wire wr_aux     = bus.wr && (bus.addr == `CT_A_AUX_CTRL);
  wire wr_mask    = bus.wr && (bus.addr == `CT_A_IRQ);
  wire wr_hi      = bus.wr && (bus.addr == `CT_A_CNT_HI);
  wire wr_lo      = bus.wr && (bus.addr == `CT_A_CNT_LO);
  wire wr_cmd_a   = bus.wr && (bus.addr == `CT_A_CMD_A);
  wire wr_cmd_b   = bus.wr && (bus.addr == `CT_A_CMD_B);
  wire [3:0] cmd  = bus.wdata[7:4];
  wire on_a       = wr_cmd_a && (cmd == `CT_CMD_TO_ON);
  wire on_b       = wr_cmd_b && (cmd == `CT_CMD_TO_ON);
  wire off_a      = wr_cmd_a && (cmd == `CT_CMD_TO_OFF);
  wire off_b      = wr_cmd_b && (cmd == `CT_CMD_TO_OFF);
  wire to_on_cmd  = on_a || on_b;
  wire to_mode    = to_a_r || to_b_r;
  wire start_rd   = bus.rd && (bus.addr == `CT_A_START) && !to_mode;
  wire stop_rd    = bus.rd && (bus.addr == `CT_A_STOP) && !to_mode;
  wire rx_ev      = (bus.rx_load_a && to_a_r) || (bus.rx_load_b && to_b_r);
  wire [15:0] divisor = {cnt_hi_r, cnt_lo_r};
  wire [1:0] src  = aux_ctrl_r[`CT_AUX_SRC_HI:`CT_AUX_SRC_LO];
  wire pre_tick   = (pre_r == `CT_PRE_LAST);
  wire ext_tick   = ext_s2_r && !ext_s3_r;
  wire tick       = (src == `CT_SRC_X1)    ? 1'b1 :
                    (src == `CT_SRC_EXT)   ? ext_tick :
                    pre_tick;
  assign mode     = to_mode ? ct_pkg::M_TIMEOUT :
                    aux_ctrl_r[`CT_AUX_TIMER] ? ct_pkg::M_TIMER : ct_pkg::M_COUNTER;

  wire cnt_last   = (cnt_r <= 16'h0001);
  wire [15:0] cnt_dec = cnt_r - 16'h0001;

  // next state of the counter in each mode
  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    out_nxt  = out_r;
    pend_nxt = pend_r;
    rdy_set  = 1'b0;
    case (mode)
      ct_pkg::M_TIMEOUT:
      begin
        if (rx_ev)
          pend_nxt = 2'b01;
        else if (tick)
        begin
          if (pend_r == 2'b01)
          begin
            cnt_nxt  = cnt_dec;
            run_nxt  = 1'b0;
            pend_nxt = 2'b10;
          end
          else if (pend_r == 2'b10)
          begin
            cnt_nxt  = divisor;
            run_nxt  = 1'b1;
            pend_nxt = 2'b00;
          end
          else if (run_r)
          begin
            cnt_nxt = cnt_dec;
            if (cnt_last)
            begin
              cnt_nxt = `CT_RST_CNT;
              run_nxt = 1'b0;
              rdy_set = 1'b1;
            end
          end
        end
      end
      ct_pkg::M_TIMER:
      begin
        if (start_rd)
          cnt_nxt = divisor;
        else if (tick)
        begin
          cnt_nxt = cnt_dec;
          if (cnt_last)
          begin
            cnt_nxt = divisor;
            out_nxt = !out_r;
            rdy_set = out_r;
          end
        end
      end
      default:
      begin
        if (start_rd)
        begin
          cnt_nxt = divisor;
          run_nxt = 1'b1;
          out_nxt = 1'b1;
        end
        else if (stop_rd)
          run_nxt = 1'b0;
        else if (tick && run_r)
        begin
          cnt_nxt = cnt_dec;
          if ((cnt_r == 16'h0001) && out_r)
          begin
            out_nxt = 1'b0;
            rdy_set = 1'b1;
          end
        end
      end
    endcase
    // time-out-on stops in any mode, and no set survives it
    if (to_on_cmd)
    begin
      run_nxt  = 1'b0;
      pend_nxt = 2'b00;
      rdy_set  = 1'b0;
    end
  end

  // counter state, external pin synchroniser and x1/16 prescaler
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r    <= `CT_RST_CNT;
      run_r    <= 1'b0;
      out_r    <= 1'b1;
      pend_r   <= 2'b00;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      pre_r    <= 4'h0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      run_r    <= run_nxt;
      out_r    <= out_nxt;
      pend_r   <= pend_nxt;
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      pre_r    <= pre_r + 4'h1;
    end
  end

  // ready flag, set beats clear; per-channel time-out enables
  wire rdy_clr = stop_rd || rx_ev || to_on_cmd;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdy_r  <= 1'b0;
      to_a_r <= 1'b0;
      to_b_r <= 1'b0;
    end
    else
    begin
      rdy_r  <= rdy_set || (rdy_r && !rdy_clr);
      to_a_r <= on_a || (to_a_r && !off_a);
      to_b_r <= on_b || (to_b_r && !off_b);
    end
  end

  // software written registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_sel_r  <= `CT_RST_BYTE;
      aux_ctrl_r <= `CT_RST_BYTE;
      irq_mask_r <= `CT_RST_BYTE;
      cnt_hi_r   <= `CT_RST_BYTE;
      cnt_lo_r   <= `CT_RST_BYTE;
    end
    else
    begin
      if (wr_clk_sel) clk_sel_r <= bus.wdata;
      if (wr_aux) aux_ctrl_r <= bus.wdata;
      if (wr_mask) irq_mask_r <= bus.wdata;
      if (wr_hi) cnt_hi_r <= bus.wdata;
      if (wr_lo) cnt_lo_r <= bus.wdata;
    end
  end

  // read data, live count and status
  wire [7:0] rd_irq = {7'h00, rdy_r} << `CT_RDY_BIT;
  wire [7:0] rd_val = (bus.addr == `CT_A_IRQ)    ? rd_irq :
                      (bus.addr == `CT_A_CNT_HI) ? cnt_r[15:8] :
                      (bus.addr == `CT_A_CNT_LO) ? cnt_r[7:0] :
                      `CT_RST_BYTE;

  wire irq_req = rdy_r && irq_mask_r[`CT_RDY_BIT];

  // outputs and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_r <= `CT_RST_BYTE;
      irq_n_r <= 1'b1;
      sel_r   <= 4'h0;
    end
    else
    begin
      if (bus.rd) rdata_r <= rd_val;
      irq_n_r <= !irq_req;
      sel_r   <= clk_sel_r[3:0];
    end
  end

  // counter-clocked units forced to 16x, same flops as the select
  assign bus.rdata  = rdata_r;
  assign bus.irq_n  = irq_n_r;
  assign ct_out     = out_r;
  assign ct_clk_sel = sel_r;
  assign os16_mode  = sel_r;

endmodule : ct_device

// ---- verilog/ct_host.sv ----
// Purpose: AHB-Lite controller driving the counter register bus and rx loads
// Assumes: single word transfers, zero wait states
// Notes:   one device bus cycle at a time, busy shown in status
`timescale 1ns/1ps
`include "ct_cfg.svh"
module ct_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  ct_if.host               bus
);

  ct_pkg::host_state_t state_r;
  logic [7:0]  daddr_r;
  logic        dwr_r;
  logic [31:0] hrdata_r;
  logic        hready_r;
  logic [3:0]  addr_r;
  logic [7:0]  wdata_r;
  logic        wr_r;
  logic        rd_r;
  logic [7:0]  last_r;
  logic        rxa_r;
  logic        rxb_r;

  // address phase capture and data phase decode
  wire ap       = hsel && hready && htrans[1];
  wire busy     = (state_r != ct_pkg::H_IDLE);
  wire wr_cmd   = dwr_r && (daddr_r == `HOST_A_CMD) && !busy;
  wire wr_rx    = dwr_r && (daddr_r == `HOST_A_RX_EV);
  wire [31:0] status = {22'h0, !bus.irq_n, busy, last_r};
  wire [31:0] rd_val = (haddr[7:0] == `HOST_A_STATUS) ? status : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      daddr_r  <= 8'h00;
      dwr_r    <= 1'b0;
      hrdata_r <= 32'h0;
      hready_r <= 1'b1;
    end
    else
    begin
      dwr_r    <= ap && hwrite;
      hready_r <= 1'b1;
      if (ap)
        daddr_r <= haddr[7:0];
      if (ap && !hwrite)
        hrdata_r <= rd_val;
    end
  end

  // device bus sequencer; count values and mode choices are software's,
  // a timer-mode count read is passed through as read, unjudged
  // values relayed as written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ct_pkg::H_IDLE;
      addr_r  <= 4'h0;
      wdata_r <= 8'h00;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      last_r  <= 8'h00;
    end
    else
    begin
      case (state_r)
        ct_pkg::H_IDLE:
        begin
          if (wr_cmd)
          begin
            addr_r  <= hwdata[11:8];
            wdata_r <= hwdata[7:0];
            rd_r    <= hwdata[`HOST_CMD_RD];
            wr_r    <= !hwdata[`HOST_CMD_RD];
            state_r <= ct_pkg::H_STRB;
          end
        end
        ct_pkg::H_STRB:
        begin
          wr_r    <= 1'b0;
          rd_r    <= 1'b0;
          state_r <= ct_pkg::H_WAIT;
        end
        ct_pkg::H_WAIT:
        begin
          last_r  <= bus.rdata;
          state_r <= ct_pkg::H_IDLE;
        end
        default:
          state_r <= ct_pkg::H_IDLE;
      endcase
    end
  end

  // receiver load pulses, one cycle each
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxa_r <= 1'b0;
      rxb_r <= 1'b0;
    end
    else
    begin
      rxa_r <= wr_rx && hwdata[0];
      rxb_r <= wr_rx && hwdata[1];
    end
  end

  assign hreadyout     = hready_r;
  assign hrdata        = hrdata_r;
  assign hresp         = 1'b0;
  assign bus.addr      = addr_r;
  assign bus.wdata     = wdata_r;
  assign bus.wr        = wr_r;
  assign bus.rd        = rd_r;
  assign bus.rx_load_a = rxa_r;
  assign bus.rx_load_b = rxb_r;

endmodule : ct_host

// ---- tb/ct_pair_sva.sv ----
// Purpose: timing checks on the register bus between host and counter
// Assumes: one hclk domain, inputs are the ct_if signals
// Notes:   mask, timer and time-out enables are shadowed from bus writes
`timescale 1ns/1ps
`include "ct_cfg.svh"
module ct_pair_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rx_load_a,
  input wire logic       rx_load_b,
  input wire logic       irq_n
);
  logic      mask_r;
  logic      timer_r;
  logic      to_a_r;
  logic      to_b_r;
  // decode of shadowed writes
  wire logic on_cmd    = wdata[7:4] == `CT_CMD_TO_ON;
  wire logic off_cmd   = wdata[7:4] == `CT_CMD_TO_OFF;
  wire logic wr_a      = wr && (addr == `CT_A_CMD_A);
  wire logic wr_b      = wr && (addr == `CT_A_CMD_B);
  wire logic mask_nxt  = (wr && addr == `CT_A_IRQ) ? wdata[`CT_RDY_BIT] : mask_r;
  wire logic timer_nxt = (wr && addr == `CT_A_AUX_CTRL) ? wdata[`CT_AUX_TIMER] : timer_r;
  wire logic to_a_nxt  = wr_a ? (on_cmd | (to_a_r & ~off_cmd)) : to_a_r;
  wire logic to_b_nxt  = wr_b ? (on_cmd | (to_b_r & ~off_cmd)) : to_b_r;

  // shadow registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {mask_r, timer_r, to_a_r, to_b_r} <= 4'h0;
    else
      {mask_r, timer_r, to_a_r, to_b_r} <= {mask_nxt, timer_nxt, to_a_nxt, to_b_nxt};
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rd_one_cycle: // read strobe is a pulse
    assert property (rd |=> !rd) else $error("read strobe longer than one cycle");
  a_irq_masked:
    assert property (!$past(mask_r) |-> irq_n) else $error("interrupt while masked");
  a_ready_irq_tie:
    assert property (rd && addr == `CT_A_IRQ && mask_r |=> rdata[3] == !irq_n)
      else $error("ready bit and interrupt disagree");
  a_status_only_ready:
    assert property (rd && addr == `CT_A_IRQ |=> (rdata & 8'hf7) == 8'h00)
      else $error("status shows bits other than ready");
  a_to_on_clear:
    assert property ((wr_a || wr_b) && on_cmd |-> ##2 irq_n)
      else $error("time-out on left ready set");
  a_stop_clear:
    assert property (rd && addr == `CT_A_STOP && !timer_r && !to_a_r && !to_b_r |-> ##2 irq_n)
      else $error("stop read left ready set");
  a_late_char:
    assert property ((rx_load_a && to_a_r) || (rx_load_b && to_b_r) |-> ##2 irq_n)
      else $error("receive load left interrupt up");
  a_unmapped_zero: // unmapped reads
    assert property (rd && addr inside {4'h0, 4'h3, 4'h8, 4'h9, 4'hb} |=> rdata == 8'h00)
      else $error("unmapped read not zero");
  a_rdata_stands: // read data holds
    assert property (!rd |=> $stable(rdata)) else $error("read data moved without read");
endmodule : ct_pair_sva

// ---- tb/uart_counter_timer_timeout_bench.sv ----
// Purpose: drives the host over AHB-Lite and judges the counter at both ends
// Assumes: zero wait state host, tick source every hclk unless selected
// Notes:   external pin free runs at hclk/8
`timescale 1ns/1ps
`include "ct_cfg.svh"
module uart_counter_timer_timeout_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        ext_clk_pin = 1'b0;
  logic [2:0]  ext_div = 3'h0;
  logic        ct_out;
  logic [3:0]  ct_clk_sel;
  logic [3:0]  os16_mode;
  int          n_fail = 0;
  int          n_tests = 0;
  ct_if bus_if ();

  ct_host i_ct_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(bus_if));
  ct_device i_ct_device (.hclk(hclk), .hresetn(hresetn), .bus(bus_if),
    .ext_clk_pin(ext_clk_pin), .ct_out(ct_out), .ct_clk_sel(ct_clk_sel),
    .os16_mode(os16_mode));
  ct_pair_sva i_ct_pair_sva (.hclk(hclk), .hresetn(hresetn), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .rx_load_a(bus_if.rx_load_a), .rx_load_b(bus_if.rx_load_b), .irq_n(bus_if.irq_n));

  // clock and free running external pin
  always #10 hclk = ~hclk;
  always @(posedge hclk)
  begin
    ext_div <= ext_div + 3'h1;
    ext_clk_pin <= ext_div[2];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // one single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  // device bus cycle through the host, waits for busy to drop
  task automatic dev(input logic rdn, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] b);
    logic [31:0] st;
    int          k;
    ahb(1'b1, `HOST_A_CMD, {16'h0000, rdn, 3'h0, a, d}, st);
    k = 0;
    st = 32'h100;
    while (st[`HOST_STAT_BUSY] !== 1'b0 && k < 20)
    begin
      ahb(1'b0, `HOST_A_STATUS, 32'h0, st);
      k++;
    end
    check(st[`HOST_STAT_BUSY], 1'b0, "host busy");
    b = st[7:0];
  endtask : dev

  task automatic rx(input logic [1:0] bits);
    logic [31:0] q;
    ahb(1'b1, `HOST_A_RX_EV, {30'h0, bits}, q);
  endtask : rx

  // waits for ct_out (sel 0) or irq_n (sel 1) to reach v
  task automatic wait_sig(input logic sel, input logic v, input int lim, output int k);
    k = 0;
    while ((sel ? bus_if.irq_n : ct_out) !== v && k < lim)
    begin
      @(posedge hclk);
      k++;
    end
  endtask : wait_sig

  task automatic t_reset();
    logic [7:0]  b;
    logic [31:0] q;
    check({ct_out, bus_if.irq_n, ct_clk_sel, os16_mode}, 10'h300, "reset");
    ahb(1'b0, 8'h0c, 32'h0, q);
    check(q | {31'h0, hresp}, 32'h0, "host unmapped");
    dev(1'b1, 4'h0, 8'h00, b);
    check(b, 8'h00, "dev unmapped");
    dev(1'b0, `CT_A_CLK_SEL, 8'h5a, b);
    check({ct_clk_sel, os16_mode}, 8'haa, "clock select");
  endtask : t_reset

  task automatic t_counter();
    logic [7:0] b;
    logic [7:0] lo1;
    int         k;
    dev(1'b0, `CT_A_IRQ, 8'h08, b);
    dev(1'b0, `CT_A_AUX_CTRL, 8'h00, b);
    dev(1'b0, `CT_A_CNT_HI, 8'h01, b);
    dev(1'b0, `CT_A_CNT_LO, 8'h00, b);
    dev(1'b1, `CT_A_START, 8'h00, b);
    dev(1'b1, `CT_A_CNT_HI, 8'h00, b);
    check(b, 8'h00, "live high");
    dev(1'b1, `CT_A_CNT_LO, 8'h00, lo1);
    dev(1'b1, `CT_A_CNT_LO, 8'h00, b);
    check(b < lo1 && ct_out, 1'b1, "counting");
    wait_sig(1'b0, 1'b0, 300, k);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check({b, ct_out, bus_if.irq_n}, 10'h020, "expiry");
    repeat (100) @(posedge hclk);
    dev(1'b1, `CT_A_CNT_HI, 8'h00, b);
    check({b, ct_out}, 9'h1fe, "wrap");
    dev(1'b1, `CT_A_STOP, 8'h00, b);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check({b, bus_if.irq_n}, 9'h001, "stop clears");
  endtask : t_counter

  task automatic t_timer();
    logic [7:0] b;
    logic [7:0] aux [3] = '{8'h40, 8'h50, 8'h60};
    int         half [3] = '{16, 256, 128};
    int         k;
    // divisor 0x0010: the high byte is rewritten to zero over the counter test's value
    dev(1'b0, `CT_A_CNT_HI, 8'h00, b);
    dev(1'b0, `CT_A_CNT_LO, 8'h10, b);
    for (int i = 0; i < 3; i++)
    begin
      dev(1'b0, `CT_A_AUX_CTRL, aux[i], b);
      dev(1'b1, `CT_A_START, 8'h00, b);
      wait_sig(1'b0, ~ct_out, 2 * half[i] + 40, k);
      wait_sig(1'b0, ~ct_out, half[i] + 40, k);
      check(k, half[i], "half period");
    end
    dev(1'b0, `CT_A_AUX_CTRL, 8'h40, b);
    dev(1'b1, `CT_A_STOP, 8'h00, b);
    repeat (40) @(posedge hclk);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check({b, bus_if.irq_n}, 9'h010, "timer runs on");
    dev(1'b0, `CT_A_IRQ, 8'h00, b);
    check(bus_if.irq_n, 1'b1, "masked ready");
    dev(1'b0, `CT_A_IRQ, 8'h08, b);
  endtask : t_timer

  task automatic t_timeout();
    logic [7:0] b;
    logic [7:0] lo1;
    int         k;
    dev(1'b0, `CT_A_AUX_CTRL, 8'h00, b);
    dev(1'b0, `CT_A_CNT_LO, 8'h20, b);
    dev(1'b0, `CT_A_CMD_A, 8'ha0, b);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check(b, 8'h00, "on clears");
    dev(1'b1, `CT_A_CNT_LO, 8'h00, lo1);
    dev(1'b1, `CT_A_START, 8'h00, b);
    dev(1'b1, `CT_A_CNT_LO, 8'h00, b);
    check(b, lo1, "held");
    rx(2'b01);
    wait_sig(1'b1, 1'b0, 60, k);
    check(k >= 30 && k <= 40, 1'b1, "expiry time");
    dev(1'b1, `CT_A_STOP, 8'h00, b);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check(b, 8'h08, "stop ignored");
    rx(2'b01);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check({b, bus_if.irq_n}, 9'h001, "late char");
    dev(1'b0, `CT_A_CMD_B, 8'ha0, b);
    for (int i = 0; i < 4; i++)
    begin
      rx(i[0] ? 2'b10 : 2'b01);
      repeat (20) @(posedge hclk);
      check(bus_if.irq_n, 1'b1, "either restarts");
    end
    wait_sig(1'b1, 1'b0, 60, k);
    check(bus_if.irq_n, 1'b0, "both idle");
    dev(1'b0, `CT_A_CMD_A, 8'hc0, b);
    dev(1'b0, `CT_A_CMD_B, 8'hc0, b);
    dev(1'b1, `CT_A_STOP, 8'h00, b);
    dev(1'b1, `CT_A_IRQ, 8'h00, b);
    check(b, 8'h00, "off restores stop");
  endtask : t_timeout

  task automatic final_report();
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_counter();
    t_timer();
    t_timeout();
    final_report();
  end

  // watchdog
  initial
  begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule : uart_counter_timer_timeout_bench
